/* rtl/ssp_host.sv */
`timescale 1ns/1ns
module ssp_host (
  input wire logic CLK,
  input wire logic RESET,
  ssp_link_if.host LINK,
  input wire logic [7:0] TX_DATA,
  input wire logic START,
  input wire logic CLOCK_IDLE_POLARITY,
  input wire logic CKE,
  input wire logic [7:0] HALF_DIV,
  output logic BUSY,
  output logic DONE,
  output logic [7:0] RX_DATA
);
  typedef enum logic [1:0] {SSPH_IDLE, SSPH_SEL, SSPH_RUN, SSPH_END} ssph_st_t;
  typedef struct packed {
    ssph_st_t st;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic [7:0] div;
    logic phase;
    logic sck;
    logic mosi;
    logic ss_n;
    logic busy;
    logic done;
    logic [7:0] rx;
  } ssph_state_t;
  ssph_state_t q, d;
  logic tick;

  always_comb begin
    d = q;
    d.done = 1'b0;
    tick = (q.div == 8'h00);
    d.div = tick ? HALF_DIV : q.div - 8'h01;
    case (q.st)
      SSPH_IDLE: begin
        d.sck = 1'b0;
        if (START) begin
          d.shift = TX_DATA;
          d.mosi = TX_DATA[7];
          d.ss_n = 1'b0;
          d.busy = 1'b1;
          d.cnt = 3'h0;
          d.phase = 1'b0;
          d.div = HALF_DIV;
          d.st = SSPH_SEL;
        end
      end
      SSPH_SEL: begin
        if (tick) d.st = SSPH_RUN;
      end
      SSPH_RUN: begin
        if (tick) begin
          d.sck = !q.sck;
          d.phase = !q.phase;
          // CKE=1: change on trailing edge, sample on leading, as the port does
          if (q.phase != CKE) begin
            d.shift = {q.shift[6:0], LINK.miso};
          end
          if (q.phase == CKE) d.mosi = q.shift[7];
          if (q.phase) begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == ssp_pkg::SSP_LAST_BIT) d.st = SSPH_END;
          end
        end
      end
      default: begin
        if (tick) begin
          d.ss_n = 1'b1;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.rx = q.shift;
          d.st = SSPH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      q <= '0;
      q.st <= SSPH_IDLE;
      q.ss_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign LINK.host_sck = q.sck ^ CLOCK_IDLE_POLARITY;
  assign LINK.mosi = q.mosi;
  assign LINK.ss_n = q.ss_n;
  assign BUSY = q.busy;
  assign DONE = q.done;
  assign RX_DATA = q.rx;
endmodule // ssp_host

/* rtl/ssp_link_if.sv */
`timescale 1ns/1ns
interface ssp_link_if;
  logic sck_o;
  logic sck_oe;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic ss_n;
  logic sck;
  logic miso;
  logic host_sck;
  // Each end owns its own clock net; one driver per signal
  assign sck = sck_oe ? sck_o : host_sck;
  assign miso = miso_oe ? miso_o : 1'b0;
  modport device (input sck, input mosi, input ss_n, output sck_o, output sck_oe,
    output miso_o, output miso_oe);
  modport host (output host_sck, output mosi, output ss_n, input sck, input miso);
endinterface

/* rtl/ssp_pkg.sv */
package ssp_pkg;
  localparam logic [2:0] SSP_A_CTRL = 3'h0;
  localparam logic [2:0] SSP_A_STAT = 3'h1;
  localparam logic [2:0] SSP_A_DATA = 3'h2;
  localparam logic [2:0] SSP_A_BAUD = 3'h3;
  localparam logic [2:0] SSP_A_IRQ = 3'h4;
  localparam int SSP_B_WRITE_COLLISION_FLAG = 7;
  localparam int SSP_B_OV = 6;
  localparam int SSP_B_EN = 5;
  localparam int SSP_B_CKP = 4;
  localparam int SSP_B_SMP = 7;
  localparam int SSP_B_CKE = 6;
  localparam int SSP_B_BF = 0;
  localparam logic [3:0] SSP_M_DIV4 = 4'h0;
  localparam logic [3:0] SSP_M_DIV16 = 4'h1;
  localparam logic [3:0] SSP_M_DIV64 = 4'h2;
  localparam logic [3:0] SSP_M_TMR = 4'h3;
  localparam logic [3:0] SSP_M_SLV_SS = 4'h4;
  localparam logic [3:0] SSP_M_SLV = 4'h5;
  localparam logic [3:0] SSP_M_BAUD = 4'hA;
  localparam logic [7:0] SSP_CTRL_RST = 8'h00;
  localparam logic [7:0] SSP_STAT_RST = 8'h00;
  localparam logic [7:0] SSP_BAUD_RST = 8'h00;
  localparam logic [7:0] SSP_TMR_HALF = 8'h3F;
  localparam logic [2:0] SSP_LAST_BIT = 3'h7;
endpackage

/* rtl/ssp_port.sv */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
module ssp_port (
  input wire logic CLK,
  input wire logic RESET,
  ssp_link_if.device LINK,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic IRQ_FLAG
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] stat_hi;
    logic [7:0] baud;
    logic [7:0] shift;
    logic [7:0] buffer;
    logic bf;
    logic irq;
    logic busy;
    logic [2:0] cnt;
    logic [7:0] div;
    logic sck;
    logic phase;
    logic so;
    logic soe;
    logic sck_oe;
    logic sck_prev;
    logic [7:0] rdata;
  } sspp_state_t;
  sspp_state_t q, d;

  function automatic logic [7:0] sspp_reload(input logic [3:0] m, input logic [7:0] b);
    case (m)
      ssp_pkg::SSP_M_DIV4: sspp_reload = 8'h01;
      ssp_pkg::SSP_M_DIV16: sspp_reload = 8'h07;
      ssp_pkg::SSP_M_DIV64: sspp_reload = 8'h1F;
      ssp_pkg::SSP_M_TMR: sspp_reload = ssp_pkg::SSP_TMR_HALF;
      default: sspp_reload = b;
    endcase
  endfunction

  logic en, clock_idle_polarity, cke, master, ss_ctl, sel, lead, trail, out_edge, in_edge;
  logic [3:0] mode;

  always_comb begin
    d = q;
    mode = q.ctrl[3:0];
    en = q.ctrl[ssp_pkg::SSP_B_EN];
    clock_idle_polarity = q.ctrl[ssp_pkg::SSP_B_CKP];
    cke = q.stat_hi[0];
    master = (mode <= ssp_pkg::SSP_M_TMR) || (mode == ssp_pkg::SSP_M_BAUD);
    ss_ctl = (mode == ssp_pkg::SSP_M_SLV_SS);
    sel = !ss_ctl || !LINK.ss_n;
    lead = 1'b0;
    trail = 1'b0;
    // Edges seen against idle level; CLOCK_IDLE_POLARITY shared with far end
    if (master) begin
      if (q.busy) begin
        if (q.div == 8'h00) begin
          d.div = sspp_reload(mode, q.baud);
          d.sck = !q.sck;
          lead = !q.phase;
          trail = q.phase;
          d.phase = !q.phase;
        end else begin
          d.div = q.div - 8'h01;
        end
      end
    end else begin
      d.sck_prev = LINK.sck ^ clock_idle_polarity;
      lead = en && sel && !q.sck_prev && (LINK.sck ^ clock_idle_polarity);
      trail = en && sel && q.sck_prev && !(LINK.sck ^ clock_idle_polarity);
    end
    // CKE=1: change on trailing edge, sample on leading
    out_edge = cke ? trail : lead;
    in_edge = cke ? lead : trail;
    if (in_edge) begin
      d.shift = {q.shift[6:0], LINK.mosi};
      d.cnt = q.cnt + 3'h1;
      if (q.cnt == ssp_pkg::SSP_LAST_BIT) begin
        d.buffer = {q.shift[6:0], LINK.mosi};
        if (q.bf) d.ctrl[ssp_pkg::SSP_B_OV] = 1'b1;
        d.bf = 1'b1;
        d.irq = 1'b1;
        d.busy = 1'b0;
      end else begin
        d.busy = 1'b1;
      end
    end
    if (out_edge && !(cke && q.cnt == 3'h0 && !q.busy)) d.so = q.shift[7];
    if (!master && !cke && !q.busy) d.so = q.shift[7];
    if (master && !q.busy) begin
      d.sck = 1'b0;
      d.phase = 1'b0;
      d.div = sspp_reload(mode, q.baud);
    end
    d.soe = en && sel;
    d.sck_oe = en && master;
    d.rdata = 8'h00;
    if (RD) begin
      if (ADDR == ssp_pkg::SSP_A_CTRL) begin
        d.rdata = q.ctrl;
      end else if (ADDR == ssp_pkg::SSP_A_STAT) begin
        d.rdata = {q.stat_hi, 5'h00, q.bf};
      end else if (ADDR == ssp_pkg::SSP_A_DATA) begin
        d.rdata = q.buffer;
        if (!(in_edge && q.cnt == ssp_pkg::SSP_LAST_BIT)) d.bf = 1'b0;
      end else if (ADDR == ssp_pkg::SSP_A_BAUD) begin
        d.rdata = q.baud;
      end else if (ADDR == ssp_pkg::SSP_A_IRQ) begin
        d.rdata = {7'h00, q.irq};
      end
    end
    if (WR) begin
      if (ADDR == ssp_pkg::SSP_A_CTRL) begin
        d.ctrl = WDATA;
        if (d.ctrl[ssp_pkg::SSP_B_WRITE_COLLISION_FLAG] == 1'b0 && q.ctrl[ssp_pkg::SSP_B_WRITE_COLLISION_FLAG]) d.ctrl = WDATA;
      end else if (ADDR == ssp_pkg::SSP_A_STAT) begin
        d.stat_hi = WDATA[7:6];
      end else if (ADDR == ssp_pkg::SSP_A_BAUD) begin
        d.baud = WDATA;
      end else if (ADDR == ssp_pkg::SSP_A_IRQ) begin
        if (WDATA[0] && !d.irq) d.irq = 1'b0;
        else if (WDATA[0] && !(in_edge && q.cnt == ssp_pkg::SSP_LAST_BIT)) d.irq = 1'b0;
      end else if (ADDR == ssp_pkg::SSP_A_DATA) begin
        if (q.busy || q.ctrl[ssp_pkg::SSP_B_WRITE_COLLISION_FLAG]) begin
          d.ctrl[ssp_pkg::SSP_B_WRITE_COLLISION_FLAG] = 1'b1;
        end else begin
          d.shift = WDATA;
          d.buffer = WDATA;
          // First bit must stand before the first sampling edge
          d.so = WDATA[7];
          if (master && en) d.busy = 1'b1;
        end
      end
    end
    // Port reset: disable, or select released in select mode
    if (!en || (ss_ctl && LINK.ss_n)) begin
      d.cnt = 3'h0;
      d.busy = 1'b0;
      d.sck = 1'b0;
      d.phase = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      q <= '0;
      q.ctrl <= ssp_pkg::SSP_CTRL_RST;
      q.baud <= ssp_pkg::SSP_BAUD_RST;
    end else begin
      q <= d;
    end
  end

  assign LINK.sck_o = q.sck ^ q.ctrl[ssp_pkg::SSP_B_CKP];
  assign LINK.sck_oe = q.sck_oe;
  assign LINK.miso_o = q.so;
  assign LINK.miso_oe = q.soe;
  assign RDATA = q.rdata;
  assign IRQ_FLAG = q.irq;
endmodule // ssp_port

/* testbench/ssp_link_props.sv */
`timescale 1ns/1ns
module ssp_link_props (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic ss_n
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  logic [5:0] edges_q;
  logic idle_q;
  // Edges counted only inside a frame; idle level kept from before it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      edges_q <= 6'h00;
      idle_q <= 1'b0;
    end else if (ss_n) begin
      edges_q <= 6'h00;
      idle_q <= sck;
    end else if ($changed(sck)) begin
      edges_q <= edges_q + 6'h01;
    end
  end
  sequence s_frame_start;
    ss_n ##1 !ss_n;
  endsequence
  sequence s_frame_end;
    !ss_n ##1 ss_n;
  endsequence
  property p_edge_count;
    s_frame_end |-> edges_q == 6'h10;
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("bad edge count");
  property p_stop_first;
    s_frame_end |-> $past(sck, 2) == sck;
  endproperty
  a_stop_first: assert property (p_stop_first) else $error("clock ran at release");
  property p_frame_len;
    s_frame_start |-> !ss_n[*8] ##[8:600] ss_n;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length off");
  property p_start_quiet;
    s_frame_start |-> $stable(sck)[*3];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("early clock");
  property p_unsel_quiet;
    ss_n[*3] |-> !miso_oe;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet) else $error("unselected drive");
  property p_mosi_hold;
    (!ss_n && $changed(mosi)) |=> $stable(mosi)[*3];
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi unstable");
  property p_miso_hold;
    (!ss_n && miso_oe && $changed(miso_o)) |=> $stable(miso_o)[*3];
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso unstable");
  property p_idle_match;
    s_frame_end |-> sck == idle_q;
  endproperty
  a_idle_match: assert property (p_idle_match) else $error("idle level lost");
endmodule // ssp_link_props

/* testbench/tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb;
  localparam logic [2:0] A_C = ssp_pkg::SSP_A_CTRL;
  localparam logic [2:0] A_S = ssp_pkg::SSP_A_STAT;
  localparam logic [2:0] A_D = ssp_pkg::SSP_A_DATA;
  localparam logic [2:0] A_I = ssp_pkg::SSP_A_IRQ;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq_flag;
  logic [7:0] tx_data = 8'h00;
  logic start = 1'b0;
  logic clock_idle_polarity = 1'b0;
  logic cke = 1'b0;
  logic done;
  logic [7:0] rx_data;
  logic [7:0] rv;
  int n_mismatch = 0;
  int total_checks = 0;
  ssp_link_if link ();
  ssp_port ssp_port_inst (.CLK(clk), .RESET(reset), .LINK(link.device), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ_FLAG(irq_flag));
  // Half period of six clocks leaves room for the slave's input sync
  ssp_host ssp_host_inst (.CLK(clk), .RESET(reset), .LINK(link.host), .TX_DATA(tx_data),
    .START(start), .CLOCK_IDLE_POLARITY(clock_idle_polarity), .CKE(cke), .HALF_DIV(8'h05), .BUSY(), .DONE(done),
    .RX_DATA(rx_data));
  ssp_link_props ssp_link_props_inst (.CLK(clk), .RESET(reset), .sck(link.sck),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe), .ss_n(link.ss_n));
  always #5 clk = ~clk;
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic host_start(input logic [7:0] h);
    @(posedge clk);
    tx_data <= h;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic host_wait;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    `CHK(done, 1'b1)
  endtask
  // Port off while reconfigured, then enabled only if en is set
  task automatic setup(input logic p, input logic e, input logic en);
    reg_wr(A_C, 8'h00);
    @(posedge clk);
    clock_idle_polarity <= p;
    cke <= e;
    reg_wr(A_S, {1'b0, e, 6'h00});
    reg_wr(A_C, {2'b00, en, p, ssp_pkg::SSP_M_SLV_SS});
    reg_wr(A_I, 8'h01);
  endtask
  task automatic xfer(input logic [7:0] h, input logic [7:0] s);
    reg_wr(A_D, s);
    host_start(h);
    host_wait();
    `CHK(rx_data, s)
    `CHK(irq_flag, 1'b1)
    reg_rd(A_S);
    `CHK(rv[ssp_pkg::SSP_B_BF], 1'b1)
    reg_rd(A_D);
    `CHK(rv, h)
    reg_rd(A_S);
    `CHK(rv[ssp_pkg::SSP_B_BF], 1'b0)
  endtask
  task automatic t_regs;
    reg_rd(A_C);
    `CHK(rv, ssp_pkg::SSP_CTRL_RST)
    reg_rd(A_S);
    `CHK(rv, ssp_pkg::SSP_STAT_RST)
    reg_rd(ssp_pkg::SSP_A_BAUD);
    `CHK(rv, ssp_pkg::SSP_BAUD_RST)
    reg_wr(A_C, 8'hDA);
    reg_rd(A_C);
    `CHK(rv, 8'hDA)
    reg_wr(A_S, 8'hFF);
    reg_rd(A_S);
    `CHK(rv, 8'hC0)
    reg_wr(ssp_pkg::SSP_A_BAUD, 8'hA5);
    reg_rd(ssp_pkg::SSP_A_BAUD);
    `CHK(rv, 8'hA5)
    reg_rd(3'h7);
    `CHK(rv, 8'h00)
    $display("registers done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      setup(m[1], m[0], 1'b1);
      xfer(8'hA5 ^ 8'(m), 8'h3C + 8'(m));
    end
    $display("modes done");
  endtask
  task automatic t_collision;
    setup(1'b0, 1'b0, 1'b1);
    reg_wr(A_D, 8'h96);
    host_start(8'h5A);
    repeat (40) @(posedge clk);
    reg_wr(A_D, 8'hFF);
    host_wait();
    `CHK(rx_data, 8'h96)
    reg_rd(A_C);
    `CHK(rv[ssp_pkg::SSP_B_WRITE_COLLISION_FLAG], 1'b1)
    reg_rd(A_D);
    `CHK(rv, 8'h5A)
    // Still flagged, so this write must be lost too
    reg_wr(A_D, 8'h11);
    host_start(8'hC3);
    host_wait();
    `CHK(rx_data, 8'h5A)
    reg_rd(A_D);
    setup(1'b0, 1'b0, 1'b1);
    #1 `CHK(irq_flag, 1'b0)
    xfer(8'h24, 8'h42);
    $display("collision done");
  endtask
  task automatic t_disable;
    setup(1'b1, 1'b1, 1'b0);
    host_start(8'hE7);
    host_wait();
    `CHK(rx_data, 8'h00)
    `CHK(irq_flag, 1'b0)
    setup(1'b1, 1'b1, 1'b1);
    xfer(8'h18, 8'hE1);
    $display("disable done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_modes();
    t_collision();
    t_disable();
    summarize();
  end
  initial begin
    #400000;
    n_mismatch++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end
endmodule // tb
